/* gsr_top.v */
// How it works
// - Three control-register fields are 64 bits, or 32 without long mode.
// - Breakpoint-control field is 64 bits, or 32 without long mode.
// - Stack pointer, instruction pointer and flags are 64 or 32 bits.
// - Eight segments each keep selector, base, limit and access rights.
// - Every segment base is 64 bits wide with long mode.
// - Segment limits are 32-bit byte counts regardless of granularity.
// - Access rights low 16 bits come from descriptor bits 55:40; 11:8 reserved.
// - Access-rights bit 16 marks unusable; use faults unless in 64-bit mode.
// - Access-rights bits 31:17 are reserved.
// - Type 3:0, kind 4, privilege 6:5, present 7, available 12.
// - Bit 13 is the 64-bit code flag for code segment only.
// - Bit 14 is default operand size, bit 15 is granularity.
// - Stack-segment privilege field is loaded from current privilege at every clock edge out of reset.
// - Table registers keep a base and a 32-bit limit.
// - Debug MSR 64 bits, syscall segment 32, syscall pointers 64 or 32.
// - A 32-bit management memory base field is kept.
// - Activity codes: 0 active, 1 halted, 2 shutdown, 3 startup wait.
// - Triple fault or serious error enters shutdown.
// - Monitor-wait sleep never shows in the activity field.
// - Interrupt-enable with flag clear sets blocking bit 0 for one instruction.
// - Entry is refused when blocking bits 31:4 are non-zero.
// - Blocking bit 3 set after NMI or SMI delivery until interrupt return.
`include "gsr_map.vh"

module gsr_top #(
   parameter LONG_CAP = 1
) (
   input  wire        ref_clk_i,      // Core clock
   input  wire        rst_n_i,        // Sync reset, active low
   input  wire        fld_wr_i,       // Field write strobe
   input  wire        fld_rd_i,       // Field read strobe
   input  wire [5:0]  fld_idx_i,      // Field index
   input  wire [63:0] fld_wdata_i,    // Field write data
   output reg  [63:0] fld_rdata_o,    // Field read data
   output reg         fld_rvalid_o,   // Read data valid pulse
   output reg         fld_bad_o,      // Unmapped index pulse
   input  wire        seg_load_i,     // Segment load from descriptor
   input  wire [2:0]  seg_load_idx_i, // Segment being loaded
   input  wire [15:0] seg_load_sel_i, // Selector loaded
   input  wire [63:0] seg_load_desc_i,// Descriptor loaded
   input  wire        seg_load_null_i,// Null selector load
   input  wire [1:0]  cur_priv_i,     // Current privilege level
   input  wire        seg_use_i,      // Segment is being used
   input  wire [2:0]  seg_use_idx_i,  // Segment used
   input  wire        long_mode_i,    // Guest runs in 64-bit mode
   output reg         seg_fault_o,    // Use of unusable segment
   input  wire        int_enable_exec_i, // Interrupt-enable instruction ran
   input  wire        if_flag_i,      // Interrupt flag before it
   input  wire        mov_ss_exec_i,  // Stack-segment load ran
   input  wire        instr_done_i,   // Instruction completed
   input  wire        nmi_deliver_i,  // NMI delivered
   input  wire        smi_deliver_i,  // Management interrupt delivered
   input  wire        iret_exec_i,    // Interrupt return ran
   input  wire        rsm_exec_i,     // Management mode left
   input  wire        halt_exec_i,    // Halt instruction ran
   input  wire        triple_fault_i, // Triple fault
   input  wire        serious_err_i,  // Other serious error
   input  wire        wait_startup_i, // Enter startup-IPI wait
   input  wire        startup_ipi_i,  // Startup IPI arrived
   input  wire        wake_i,         // Wake from halt
   input  wire        monitor_wait_i, // Monitor-wait instruction ran
   input  wire        entry_req_i,    // Guest entry requested
   output reg         entry_ok_o,     // Entry accepted pulse
   output reg         entry_fail_o,   // Entry refused pulse
   output reg  [1:0]  activity_o      // Activity code
);

   localparam [63:0] ALL64 = 64'hffff_ffff_ffff_ffff;
   localparam [63:0] LOW32 = 64'h0000_0000_ffff_ffff;
   localparam [63:0] NAT   = LONG_CAP ? ALL64 : LOW32;

   reg  [63:0] plain_q [0:15];
   wire [15:0] seg_sel   [0:7];
   wire [63:0] seg_base  [0:7];
   wire [31:0] seg_limit [0:7];
   wire [31:0] seg_ar    [0:7];
   wire [31:0] blk_w;
   wire [31:0] act_w;
   integer     i;

   // Plain fields share one array; slot 0..6 core registers, 7..15 tables/MSRs
   function [4:0] slot_of;
      input [5:0] idx;
      begin
         if (idx <= `GSR_F_FLAGS) begin
            slot_of = {1'b1, idx[3:0]};
         end else if (idx >= `GSR_F_GTAB_BASE && idx <= `GSR_F_MGMT_BASE) begin
            slot_of = {1'b1, idx[3:0] + 4'h7};
         end else begin
            slot_of = 5'h00;
         end
      end
   endfunction

   function [63:0] mask_of;
      input [5:0] idx;
      begin
         case (idx)
            `GSR_F_DBG_MSR:   mask_of = ALL64;
            `GSR_F_GTAB_LIM,
            `GSR_F_ITAB_LIM:  mask_of = LOW32;
            `GSR_F_SC_CS:     mask_of = LOW32;
            `GSR_F_MGMT_BASE: mask_of = LOW32;
            default:          mask_of = NAT;
         endcase
      end
   endfunction

   wire [4:0] wr_slot  = slot_of(fld_idx_i);
   wire       seg_hit  = fld_idx_i >= `GSR_F_SEG_FIRST && fld_idx_i <= `GSR_F_SEG_LAST;
   wire [5:0] seg_off  = fld_idx_i - `GSR_F_SEG_FIRST;
   wire [2:0] seg_num  = seg_off[4:2];
   wire [1:0] seg_kind = seg_off[1:0];

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         for (i = 0; i < 16; i = i + 1) begin
            plain_q[i] <= `GSR_FIELD_RST;
         end
      end else if (fld_wr_i && wr_slot[4]) begin
         plain_q[wr_slot[3:0]] <= fld_wdata_i & mask_of(fld_idx_i);
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : gen_seg
         gsr_seg_reg #(
            .IS_CS    (g == `GSR_SEG_CS),
            .IS_SS    (g == `GSR_SEG_SS),
            .LONG_CAP (LONG_CAP)
         ) u_seg (
            .ref_clk_i   (ref_clk_i),
            .rst_n_i     (rst_n_i),
            .wr_i        (fld_wr_i && seg_hit && seg_num == g),
            .wr_kind_i   (seg_kind),
            .wr_data_i   (fld_wdata_i),
            .load_i      (seg_load_i && seg_load_idx_i == g),
            .load_sel_i  (seg_load_sel_i),
            .load_desc_i (seg_load_desc_i),
            .load_null_i (seg_load_null_i),
            .cur_priv_i  (cur_priv_i),
            .sel_q       (seg_sel[g]),
            .base_q      (seg_base[g]),
            .limit_q     (seg_limit[g]),
            .ar_q        (seg_ar[g])
         );
      end
   endgenerate

   gsr_event_block u_blk (
      .ref_clk_i      (ref_clk_i),
      .rst_n_i        (rst_n_i),
      .wr_blk_i       (fld_wr_i && fld_idx_i == `GSR_F_BLOCKING),
      .wr_act_i       (fld_wr_i && fld_idx_i == `GSR_F_ACTIVITY),
      .wr_data_i      (fld_wdata_i[31:0]),
      .int_enable_exec_i (int_enable_exec_i),
      .if_flag_i      (if_flag_i),
      .mov_ss_exec_i  (mov_ss_exec_i),
      .instr_done_i   (instr_done_i),
      .nmi_deliver_i  (nmi_deliver_i),
      .smi_deliver_i  (smi_deliver_i),
      .iret_exec_i    (iret_exec_i),
      .rsm_exec_i     (rsm_exec_i),
      .halt_exec_i    (halt_exec_i),
      .triple_fault_i (triple_fault_i),
      .serious_err_i  (serious_err_i),
      .wait_startup_i (wait_startup_i),
      .startup_ipi_i  (startup_ipi_i),
      .wake_i         (wake_i),
      .monitor_wait_i (monitor_wait_i),
      .blk_q          (blk_w),
      .act_q          (act_w)
   );

   // Read mux; a read in the write cycle sees the old value
   reg [63:0] rd_d;
   reg        bad_d;

   always @* begin
      rd_d  = 64'h0000_0000_0000_0000;
      bad_d = 1'b0;
      if (wr_slot[4]) begin
         rd_d = plain_q[wr_slot[3:0]];
      end else if (seg_hit) begin
         case (seg_kind)
            `GSR_K_SEL:   rd_d = {48'h0, seg_sel[seg_num]};
            `GSR_K_BASE:  rd_d = seg_base[seg_num];
            `GSR_K_LIMIT: rd_d = {32'h0, seg_limit[seg_num]};
            default:      rd_d = {32'h0, seg_ar[seg_num]};
         endcase
      end else if (fld_idx_i == `GSR_F_ACTIVITY) begin
         rd_d = {32'h0, act_w};
      end else if (fld_idx_i == `GSR_F_BLOCKING) begin
         rd_d = {32'h0, blk_w};
      end else begin
         bad_d = 1'b1;
      end
   end

   wire blk_reserved = |blk_w[31:4];

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         fld_rdata_o  <= 64'h0000_0000_0000_0000;
         fld_rvalid_o <= 1'b0;
         fld_bad_o    <= 1'b0;
         seg_fault_o  <= 1'b0;
         entry_ok_o   <= 1'b0;
         entry_fail_o <= 1'b0;
         activity_o   <= 2'h0;
      end else begin
         fld_rvalid_o <= fld_rd_i;
         fld_bad_o    <= (fld_rd_i || fld_wr_i) && bad_d;
         if (fld_rd_i) begin
            fld_rdata_o <= rd_d;
         end
         seg_fault_o  <= seg_use_i && seg_ar[seg_use_idx_i][`GSR_AR_UNUSABLE]
                         && !long_mode_i;
         entry_fail_o <= entry_req_i && blk_reserved;
         entry_ok_o   <= entry_req_i && !blk_reserved;
         activity_o   <= act_w[1:0];
      end
   end

endmodule // gsr_top

/* gsr_map.vh */
`ifndef GSR_MAP_VH
`define GSR_MAP_VH

// Field index space of the transition port
`define GSR_F_CTL0       6'h00
`define GSR_F_CTL3       6'h01
`define GSR_F_CTL4       6'h02
`define GSR_F_BRK_CTL    6'h03
`define GSR_F_STACK_PTR  6'h04
`define GSR_F_INSTR_PTR  6'h05
`define GSR_F_FLAGS      6'h06
`define GSR_F_SEG_FIRST  6'h10
`define GSR_F_SEG_LAST   6'h2f
`define GSR_F_GTAB_BASE  6'h30
`define GSR_F_GTAB_LIM   6'h31
`define GSR_F_ITAB_BASE  6'h32
`define GSR_F_ITAB_LIM   6'h33
`define GSR_F_DBG_MSR    6'h34
`define GSR_F_SC_CS      6'h35
`define GSR_F_SC_SP      6'h36
`define GSR_F_SC_IP      6'h37
`define GSR_F_MGMT_BASE  6'h38
`define GSR_F_ACTIVITY   6'h39
`define GSR_F_BLOCKING   6'h3a

// Segment field kinds (low two index bits) and segment numbers
`define GSR_K_SEL        2'h0
`define GSR_K_BASE       2'h1
`define GSR_K_LIMIT      2'h2
`define GSR_K_AR         2'h3
`define GSR_SEG_CS       3'h0
`define GSR_SEG_SS       3'h1

// Access-rights layout
`define GSR_AR_PRIV_LO   5
`define GSR_AR_LONG      13
`define GSR_AR_UNUSABLE  16
`define GSR_AR_WMASK     32'h0001_f0ff
`define GSR_AR_RST       32'h0001_0000

// Descriptor bit positions (64-bit descriptor)
`define GSR_D_GRAN       55

// Activity codes
`define GSR_ACT_ACTIVE   32'h0000_0000
`define GSR_ACT_HALT     32'h0000_0001
`define GSR_ACT_SHUTDOWN 32'h0000_0002
`define GSR_ACT_WAIT_SU  32'h0000_0003

// Event-blocking bit positions
`define GSR_BLK_INT_EN   0
`define GSR_BLK_MOVSS    1
`define GSR_BLK_SMI      2
`define GSR_BLK_NMI      3

// Reset values
`define GSR_FIELD_RST    64'h0000_0000_0000_0000
`define GSR_BLK_RST      32'h0000_0000
`define GSR_SEL_RST      16'h0000

`endif

/* gsr_seg_reg.v */
`include "gsr_map.vh"

module gsr_seg_reg #(
   parameter IS_CS    = 0,
   parameter IS_SS    = 0,
   parameter LONG_CAP = 1
) (
   input  wire        ref_clk_i,    // Core clock
   input  wire        rst_n_i,      // Sync reset, active low
   input  wire        wr_i,         // Field write for this segment
   input  wire [1:0]  wr_kind_i,    // Which of the four fields
   input  wire [63:0] wr_data_i,    // Write data
   input  wire        load_i,       // Segment load from a descriptor
   input  wire [15:0] load_sel_i,   // Selector being loaded
   input  wire [63:0] load_desc_i,  // Whole descriptor
   input  wire        load_null_i,  // Null selector loaded
   input  wire [1:0]  cur_priv_i,   // Current privilege level
   output reg  [15:0] sel_q,        // Selector
   output reg  [63:0] base_q,       // Base
   output reg  [31:0] limit_q,      // Limit in bytes
   output reg  [31:0] ar_q          // Access rights
);

   localparam [31:0] AR_MASK   = IS_CS ? `GSR_AR_WMASK :
                                 (`GSR_AR_WMASK & ~(32'h1 << `GSR_AR_LONG));
   localparam [63:0] BASE_MASK = LONG_CAP ? 64'hffff_ffff_ffff_ffff :
                                            64'h0000_0000_ffff_ffff;

   wire [19:0] lim20   = {load_desc_i[51:48], load_desc_i[15:0]};
   wire [31:0] lim_dsc = load_desc_i[`GSR_D_GRAN] ? {lim20, 12'hfff} : {12'h000, lim20};
   wire [31:0] ar_dsc  = {15'h0000, load_null_i, load_desc_i[55:40]} & AR_MASK;
   wire [63:0] base_ds = {32'h0000_0000, load_desc_i[63:56], load_desc_i[39:16]};

   reg  [31:0] ar_d;

   always @* begin
      ar_d = ar_q;
      if (load_i) begin
         ar_d = ar_dsc;
      end else if (wr_i && wr_kind_i == `GSR_K_AR) begin
         ar_d = wr_data_i[31:0] & AR_MASK;
      end
      if (IS_SS) begin
         ar_d[`GSR_AR_PRIV_LO+1:`GSR_AR_PRIV_LO] = cur_priv_i;
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sel_q   <= `GSR_SEL_RST;
         base_q  <= `GSR_FIELD_RST;
         limit_q <= 32'h0000_0000;
         ar_q    <= `GSR_AR_RST;
      end else begin
         ar_q <= ar_d;
         if (load_i) begin
            sel_q <= load_sel_i;
            // A null load keeps the stale cache; only the unusable flag matters
            if (!load_null_i) begin
               base_q  <= base_ds;
               limit_q <= lim_dsc;
            end
         end else if (wr_i) begin
            case (wr_kind_i)
               `GSR_K_SEL:   sel_q   <= wr_data_i[15:0];
               `GSR_K_BASE:  base_q  <= wr_data_i & BASE_MASK;
               `GSR_K_LIMIT: limit_q <= wr_data_i[31:0];
               default:      sel_q   <= sel_q;
            endcase
         end
      end
   end

endmodule // gsr_seg_reg

/* gsr_event_block.v */
`include "gsr_map.vh"

module gsr_event_block (
   input  wire        ref_clk_i,     // Core clock
   input  wire        rst_n_i,       // Sync reset, active low
   input  wire        wr_blk_i,      // Software write of blocking field
   input  wire        wr_act_i,      // Software write of activity field
   input  wire [31:0] wr_data_i,     // Write data
   input  wire        int_enable_exec_i, // Interrupt-enable instruction ran
   input  wire        if_flag_i,     // Interrupt flag before it ran
   input  wire        mov_ss_exec_i, // Stack-segment load ran
   input  wire        instr_done_i,  // Next instruction completed
   input  wire        nmi_deliver_i, // NMI delivered
   input  wire        smi_deliver_i, // Management interrupt delivered
   input  wire        iret_exec_i,   // Interrupt return ran
   input  wire        rsm_exec_i,    // Leave management mode
   input  wire        halt_exec_i,   // Halt instruction ran
   input  wire        triple_fault_i,// Fault while delivering double fault
   input  wire        serious_err_i, // Other fatal error
   input  wire        wait_startup_i, // Enter wait for startup IPI
   input  wire        startup_ipi_i, // Startup IPI arrived
   input  wire        wake_i,        // Wake event for halted state
   input  wire        monitor_wait_i,// Monitor-wait instruction ran
   output reg  [31:0] blk_q,         // Event-blocking state
   output reg  [31:0] act_q          // Activity state
);

   reg [31:0] blk_d;
   reg [31:0] act_d;

   always @* begin
      blk_d = blk_q;
      if (wr_blk_i) begin
         blk_d = wr_data_i;
      end
      // Clears first so that a coinciding set survives
      if (instr_done_i) begin
         blk_d[`GSR_BLK_INT_EN] = 1'b0;
         blk_d[`GSR_BLK_MOVSS] = 1'b0;
      end
      if (iret_exec_i) begin
         blk_d[`GSR_BLK_NMI] = 1'b0;
      end
      if (rsm_exec_i) begin
         blk_d[`GSR_BLK_SMI] = 1'b0;
      end
      if (int_enable_exec_i && !if_flag_i) begin
         blk_d[`GSR_BLK_INT_EN] = 1'b1;
      end
      if (mov_ss_exec_i) begin
         blk_d[`GSR_BLK_MOVSS] = 1'b1;
      end
      if (smi_deliver_i) begin
         blk_d[`GSR_BLK_SMI] = 1'b1;
      end
      if (nmi_deliver_i || smi_deliver_i) begin
         blk_d[`GSR_BLK_NMI] = 1'b1;
      end
   end

   always @* begin
      act_d = act_q;
      if (wr_act_i) begin
         act_d = wr_data_i;
      end
      // Monitor-wait sleep is invisible here, so monitor_wait_i has no effect
      if (monitor_wait_i) begin
         act_d = act_d;
      end
      if (triple_fault_i || serious_err_i) begin
         act_d = `GSR_ACT_SHUTDOWN;
      end else if (wait_startup_i) begin
         act_d = `GSR_ACT_WAIT_SU;
      end else if (halt_exec_i) begin
         act_d = `GSR_ACT_HALT;
      end else if (startup_ipi_i && act_q == `GSR_ACT_WAIT_SU) begin
         act_d = `GSR_ACT_ACTIVE;
      end else if (wake_i && act_q == `GSR_ACT_HALT) begin
         act_d = `GSR_ACT_ACTIVE;
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         blk_q <= `GSR_BLK_RST;
         act_q <= `GSR_ACT_ACTIVE;
      end else begin
         blk_q <= blk_d;
         act_q <= act_d;
      end
   end

endmodule // gsr_event_block

/* gsr_top_asserts.sv */
module gsr_checker (
   input wire        ref_clk_i,      // Clock
   input wire        rst_n_i,        // Reset
   input wire        fld_wr_i,       // Write
   input wire        fld_rd_i,       // Read
   input wire [5:0]  fld_idx_i,      // Index
   input wire [63:0] fld_rdata_o,    // Read data
   input wire        fld_rvalid_o,   // Valid
   input wire        fld_bad_o,      // Unmapped
   input wire        seg_use_i,      // Use
   input wire        long_mode_i,    // 64-bit mode
   input wire        seg_fault_o,    // Fault
   input wire        halt_exec_i,    // Halt
   input wire        triple_fault_i, // Triple fault
   input wire        serious_err_i,  // Serious error
   input wire        wait_startup_i, // Startup wait
   input wire        entry_req_i,    // Entry
   input wire        entry_ok_o,     // Accepted
   input wire        entry_fail_o,   // Refused
   input wire [1:0]  activity_o      // Activity
);
   timeunit 1ns;
   timeprecision 1ns;
   wire unmap = (fld_idx_i > 6'h06 && fld_idx_i < 6'h10) || fld_idx_i > 6'h3a;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_RVALID: assert property (fld_rd_i |=> fld_rvalid_o)
      else $error("read gave no valid");
   AST_RDATA_HOLD: assert property (!fld_rd_i |=> $stable(fld_rdata_o))
      else $error("read data moved without a read");
   AST_BAD: assert property ((fld_rd_i || fld_wr_i) |=> fld_bad_o == $past(unmap))
      else $error("unmapped flag wrong");
   AST_UNMAP_ZERO: assert property (fld_rd_i && unmap |=> fld_rdata_o == 64'h0)
      else $error("unmapped read not zero");
   AST_ENTRY_ONE: assert property (entry_req_i |=> entry_ok_o != entry_fail_o)
      else $error("entry answer not exactly one");
   AST_ENTRY_IDLE: assert property (!entry_req_i |=> !entry_ok_o && !entry_fail_o)
      else $error("entry answer without request");
   AST_SEG_LONG: assert property ((!seg_use_i || long_mode_i) |=> !seg_fault_o)
      else $error("segment fault in long mode or unused");
   AST_SHUTDOWN: assert property ((triple_fault_i || serious_err_i) |-> ##2 activity_o == 2'h2)
      else $error("no shutdown after fatal event");
   AST_WAIT: assert property (wait_startup_i && !triple_fault_i && !serious_err_i
         |-> ##2 activity_o == 2'h3)
      else $error("no startup wait state");
   AST_HALT: assert property (
         halt_exec_i && !(triple_fault_i || serious_err_i || wait_startup_i)
         |-> ##2 activity_o == 2'h1)
      else $error("no halted state");
endmodule // gsr_checker

bind gsr_top gsr_checker i_chk (.ref_clk_i, .rst_n_i, .fld_wr_i, .fld_rd_i, .fld_idx_i,
   .fld_rdata_o, .fld_rvalid_o, .fld_bad_o, .seg_use_i, .long_mode_i, .seg_fault_o,
   .halt_exec_i, .triple_fault_i, .serious_err_i, .wait_startup_i, .entry_req_i, .entry_ok_o,
   .entry_fail_o, .activity_o);

/* gsr_tb.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [17:0] ev;
      logic [5:0]  idx;
      logic [63:0] exp;
   } gsr_row_t;
   localparam logic [63:0] ones = 64'hffff_ffff_ffff_ffff;
   logic        ref_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        fld_wr_i = 1'b0;
   logic        fld_rd_i = 1'b0;
   logic [5:0]  fld_idx_i = 6'h00;
   logic [63:0] fld_wdata_i = 64'h0;
   logic        seg_load_i = 1'b0;
   logic [2:0]  seg_load_idx_i = 3'h0;
   logic [15:0] seg_load_sel_i = 16'h0;
   logic [63:0] seg_load_desc_i = 64'h0;
   logic        seg_load_null_i = 1'b0;
   logic [1:0]  cur_priv_i = 2'h0;
   logic [2:0]  seg_use_idx_i = 3'h0;
   logic [17:0] ev = 18'h0;
   wire  [63:0] fld_rdata_o;
   wire         fld_rvalid_o;
   wire         fld_bad_o;
   wire         seg_fault_o;
   wire         entry_ok_o;
   wire         entry_fail_o;
   wire  [1:0]  activity_o;
   int          errors = 0;
   int          comparisons = 0;
   // Event bits: 0 ien 1 if 2 movss 3 done 4 nmi 5 smi 6 iret 7 rsm 8 halt 9 triple
   // 10 serious 11 wait 12 startup 13 wake 14 monw 15 entry 16 use 17 long
   gsr_row_t rows[] = '{
      '{18'h0, 6'h00, ones},
      '{18'h0, 6'h01, ones},
      '{18'h0, 6'h02, ones},
      '{18'h0, 6'h03, ones},
      '{18'h0, 6'h04, ones},
      '{18'h0, 6'h05, ones},
      '{18'h0, 6'h06, ones},
      '{18'h0, 6'h10, 64'hffff},
      '{18'h0, 6'h11, ones},
      '{18'h0, 6'h12, 64'hffff_ffff},
      '{18'h0, 6'h13, 64'h1_f0ff},
      '{18'h0, 6'h1b, 64'h1_d0ff},
      '{18'h0, 6'h2c, 64'hffff},
      '{18'h0, 6'h2d, ones},
      '{18'h0, 6'h2f, 64'h1_d0ff},
      '{18'h0, 6'h30, ones},
      '{18'h0, 6'h31, 64'hffff_ffff},
      '{18'h0, 6'h33, 64'hffff_ffff},
      '{18'h0, 6'h34, ones},
      '{18'h0, 6'h35, 64'hffff_ffff},
      '{18'h0, 6'h37, ones},
      '{18'h0, 6'h38, 64'hffff_ffff},
      '{18'h0, 6'h07, 64'h0},
      '{18'h0, 6'h3f, 64'h0},
      '{18'h00001, 6'h3a, 64'h1},
      '{18'h00008, 6'h3a, 64'h0},
      '{18'h00003, 6'h3a, 64'h0},
      '{18'h00004, 6'h3a, 64'h2},
      '{18'h00009, 6'h3a, 64'h1},
      '{18'h00008, 6'h3a, 64'h0},
      '{18'h00010, 6'h3a, 64'h8},
      '{18'h00040, 6'h3a, 64'h0},
      '{18'h00020, 6'h3a, 64'hc},
      '{18'h00080, 6'h3a, 64'h8},
      '{18'h00040, 6'h3a, 64'h0},
      '{18'h00100, 6'h39, 64'h1},
      '{18'h02000, 6'h39, 64'h0},
      '{18'h00800, 6'h39, 64'h3},
      '{18'h01000, 6'h39, 64'h0},
      '{18'h04000, 6'h39, 64'h0},
      '{18'h00300, 6'h39, 64'h2},
      '{18'h03000, 6'h39, 64'h2}
   };

   gsr_top #(.LONG_CAP(1)) i_dut (.ref_clk_i, .rst_n_i, .fld_wr_i, .fld_rd_i, .fld_idx_i,
      .fld_wdata_i, .fld_rdata_o, .fld_rvalid_o, .fld_bad_o, .seg_load_i, .seg_load_idx_i,
      .seg_load_sel_i, .seg_load_desc_i, .seg_load_null_i, .cur_priv_i, .seg_use_i(ev[16]),
      .seg_use_idx_i, .long_mode_i(ev[17]), .seg_fault_o, .int_enable_exec_i(ev[0]),
      .if_flag_i(ev[1]), .mov_ss_exec_i(ev[2]), .instr_done_i(ev[3]), .nmi_deliver_i(ev[4]),
      .smi_deliver_i(ev[5]), .iret_exec_i(ev[6]), .rsm_exec_i(ev[7]), .halt_exec_i(ev[8]),
      .triple_fault_i(ev[9]), .serious_err_i(ev[10]), .wait_startup_i(ev[11]),
      .startup_ipi_i(ev[12]), .wake_i(ev[13]), .monitor_wait_i(ev[14]),
      .entry_req_i(ev[15]), .entry_ok_o, .entry_fail_o, .activity_o);

   always #10 ref_clk_i = ~ref_clk_i;

   function automatic logic unmap(input logic [5:0] x);
      return (x > 6'h06 && x < 6'h10) || x > 6'h3a;
   endfunction

   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [63:0] d);
      @(negedge ref_clk_i);
      fld_wr_i = 1'b1;
      fld_idx_i = idx;
      fld_wdata_i = d;
      @(negedge ref_clk_i);
      fld_wr_i = 1'b0;
   endtask

   task automatic rd(input logic [5:0] idx, input logic [63:0] exp);
      @(negedge ref_clk_i);
      fld_rd_i = 1'b1;
      fld_idx_i = idx;
      @(negedge ref_clk_i);
      fld_rd_i = 1'b0;
      chk("rvalid", 64'h1, {63'h0, fld_rvalid_o});
      chk("rdata", exp, fld_rdata_o);
   endtask

   // Outputs of the taking edge are settled when this returns
   task automatic pulse(input logic [17:0] v);
      @(negedge ref_clk_i);
      ev = v;
      @(negedge ref_clk_i);
      ev = 18'h0;
   endtask

   task automatic load(input logic [2:0] s, input logic [63:0] d, input logic n);
      @(negedge ref_clk_i);
      seg_load_i = 1'b1;
      seg_load_idx_i = s;
      seg_load_sel_i = n ? 16'h0 : 16'h1234;
      seg_load_desc_i = d;
      seg_load_null_i = n;
      @(negedge ref_clk_i);
      seg_load_i = 1'b0;
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge ref_clk_i);
      errors++;
      tally_and_finish();
   end

   initial begin
      logic [63:0] blk [3];
      blk = '{64'h8, 64'h10, 64'h8000_0000};
      repeat (10) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      foreach (rows[i]) begin
         if (rows[i].ev == 18'h0) begin
            wr(rows[i].idx, ones);
         end else begin
            pulse(rows[i].ev);
         end
         rd(rows[i].idx, rows[i].exp);
         chk("bad", {63'h0, unmap(rows[i].idx)}, {63'h0, fld_bad_o});
         if (rows[i].idx == 6'h39) begin
            chk("activity", rows[i].exp, {62'h0, activity_o});
         end
      end
      foreach (blk[i]) begin
         wr(6'h3a, blk[i]);
         pulse(18'h08000);
         chk("entry_fail", {63'h0, blk[i] > 64'hf}, {63'h0, entry_fail_o});
         chk("entry_ok", {63'h0, blk[i] <= 64'hf}, {63'h0, entry_ok_o});
      end
      wr(6'h39, 64'h0);
      pulse(18'h00400);
      rd(6'h39, 64'h2);
      load(3'h2, 64'h12f0_9a34_5678_0001, 1'b0);
      rd(6'h18, 64'h1234);
      rd(6'h19, 64'h1234_5678);
      rd(6'h1a, 64'h1fff);
      rd(6'h1b, 64'hd09a);
      load(3'h0, 64'h1270_9a34_5678_0001, 1'b0);
      rd(6'h12, 64'h1);
      rd(6'h13, 64'h709a);
      seg_use_idx_i = 3'h2;
      pulse(18'h10000);
      chk("fault_usable", 64'h0, {63'h0, seg_fault_o});
      load(3'h2, 64'h0, 1'b1);
      rd(6'h18, 64'h0);
      pulse(18'h10000);
      chk("fault_unusable", 64'h1, {63'h0, seg_fault_o});
      pulse(18'h30000);
      chk("fault_long", 64'h0, {63'h0, seg_fault_o});
      cur_priv_i = 2'h3;
      wr(6'h17, 64'h0);
      rd(6'h17, 64'h60);
      cur_priv_i = 2'h1;
      rd(6'h17, 64'h20);
      wr(6'h17, ones);
      rd(6'h17, 64'h1_d0bf);
      // Second reset in mid-run
      rst_n_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      rd(6'h13, 64'h1_0000);
      rd(6'h17, 64'h1_0020);
      rd(6'h39, 64'h0);
      rd(6'h3a, 64'h0);
      rd(6'h00, 64'h0);
      chk("activity_rst", 64'h0, {62'h0, activity_o});
      tally_and_finish();
   end
endmodule // testbench
